// File: verilog/rsq_sequencer.sv
`timescale 1ns/1ps
// How it works
// - every output owns an independent turn-on trigger.
// - trigger is another rail power ok, input supply ok, or a pin.
// - rail-triggered output waits until its source rail reports power ok.
// - trigger choice is fixed by the factory image, not by writes.
// - active trigger starts that output's own turn-on delay, then enable.
// - inactive trigger starts that output's own turn-off delay, then disable.
// - delay fields are writable and reset to factory defaults.
// - turn-off delays also apply on light sleep, deep sleep, shutdown.
// - fault turns every output off at once, no delay.
// - step-down rails use the primary setpoint when active, no scaling.
// - alternate setpoint optionally used in scaling, light and deep sleep.
// - linear regulator has one writable setpoint with factory default.
// - scaling never changes sequencing state, only the regulation target.
// - alternate setpoint while scaling trigger active or its sleep bit set in sleep, primary otherwise.
// - one factory-chosen pin can request scaling for both step-down rails.
// - three writable request bits; a 1 scales every rail bound to it.
// - each step-down rail selects which request bit controls its scaling.
// - default: rail one never scales, rail two follows request bit a.
// - scaling comes from the pin or from the request bits, never both.
// - an output pin mirrors one rail's power ok for external supplies.
// - an input pin carries an external supply's power good as trigger.
// - setpoint voltage is 600 mV plus 50 mV per code step.
module rsq_sequencer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic input_supply_ok_i,
  input wire logic external_power_good_i,
  input wire logic gpio_trigger_i,
  input wire logic gpio_scaling_i,
  input wire logic [2:0] power_ok_signal_i,
  input wire logic light_sleep_i,
  input wire logic deep_sleep_state_i,
  input wire logic shutdown_i,
  input wire logic fault_i,
  output logic [2:0] rail_enable_o,
  output logic [5:0] step_one_setpoint_o,
  output logic [5:0] step_two_setpoint_o,
  output logic [5:0] linear_reg_setpoint_o,
  output logic gpio_power_ok_o,
  output logic gpio_power_ok_oe_o
);
  localparam int RC = rsq_pkg::RAIL_COUNT;

  // ==========================================================================
  // pin synchronisers: three flops, a change counts once flops two and three agree
  // ==========================================================================
  logic [rsq_pkg::SYNC_W-1:0] sync_raw;
  logic [rsq_pkg::SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [rsq_pkg::SYNC_W-1:0] filt_next;

  assign sync_raw = {fault_i, shutdown_i, deep_sleep_state_i, light_sleep_i, gpio_scaling_i,
                     power_ok_signal_i, gpio_trigger_i, external_power_good_i, input_supply_ok_i};

  always_comb begin
    filt_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & filt_reg);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= sync_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  logic [2:0] rail_ok_f;
  logic fault_f, shutdown_f, sleep_any, scale_pin_f;
  logic [5:0] src_vec;
  assign rail_ok_f = filt_reg[5:3];
  assign scale_pin_f = filt_reg[6];
  assign sleep_any = filt_reg[7] | filt_reg[8];
  assign shutdown_f = filt_reg[9];
  assign fault_f = filt_reg[10];
  assign src_vec = {rail_ok_f, filt_reg[2:0]};

  // ==========================================================================
  // delay tick divider
  // ==========================================================================
  logic [7:0] div_reg, div_next;
  logic tick_reg, tick_next;

  always_comb begin
    tick_next = (div_reg == rsq_pkg::TICK_LAST);
    div_next = tick_next ? 8'h00 : div_reg + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ==========================================================================
  // configuration registers over wishbone
  // ==========================================================================
  logic [31:0] cfg_reg [rsq_pkg::CFG_COUNT];
  logic [31:0] cfg_next [rsq_pkg::CFG_COUNT];
  logic [31:0] dat_reg, dat_next;
  logic ack_reg, ack_next;
  logic [31:0] status_word, target_word;
  logic [31:0] lane_mask;
  logic access;

  assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    ack_next = access;
    dat_next = 32'h0000_0000;
    for (int r = 0; r < rsq_pkg::CFG_COUNT; r++) begin
      cfg_next[r] = cfg_reg[r];
      // byte lanes honoured; reserved bits never stick
      if (access && wb_we_i && wb_adr_i == 8'(r * 4)) begin
        cfg_next[r] = ((cfg_reg[r] & ~lane_mask) | (wb_dat_i & lane_mask))
                      & rsq_pkg::CFG_MASK[r];
      end
      if (access && !wb_we_i && wb_adr_i == 8'(r * 4)) begin
        dat_next = cfg_reg[r];
      end
    end
    if (access && !wb_we_i && wb_adr_i == rsq_pkg::STATUS_OFS) begin
      dat_next = status_word;
    end
    if (access && !wb_we_i && wb_adr_i == rsq_pkg::TARGET_OFS) begin
      dat_next = target_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int r = 0; r < rsq_pkg::CFG_COUNT; r++) begin
        cfg_reg[r] <= rsq_pkg::CFG_RESET[r];
      end
      dat_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      for (int r = 0; r < rsq_pkg::CFG_COUNT; r++) begin
        cfg_reg[r] <= cfg_next[r];
      end
      dat_reg <= dat_next;
      ack_reg <= ack_next;
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;

  // ==========================================================================
  // per-output sequencing
  // ==========================================================================
  rsq_pkg::rsq_state_type state_reg [RC];
  rsq_pkg::rsq_state_type state_next [RC];
  logic [3:0] cnt_reg [RC];
  logic [3:0] cnt_next [RC];
  logic [3:0] on_dly [RC];
  logic [3:0] off_dly [RC];
  logic [RC-1:0] trig, en_reg, en_next;

  always_comb begin
    for (int i = 0; i < RC; i++) begin
      on_dly[i] = cfg_reg[0][4*i +: 4];
      off_dly[i] = cfg_reg[1][4*i +: 4];
      // factory-fixed source; sleep and shutdown drop it so off delays apply
      trig[i] = src_vec[rsq_pkg::TRIG_SEL[i]] & ~sleep_any & ~shutdown_f;
      state_next[i] = state_reg[i];
      cnt_next[i] = cnt_reg[i];
      unique case (state_reg[i])
        rsq_pkg::RSQ_OFF: begin
          if (!fault_f && trig[i]) begin
            state_next[i] = (on_dly[i] == 4'h0) ? rsq_pkg::RSQ_ON : rsq_pkg::RSQ_ON_WAIT;
            cnt_next[i] = on_dly[i];
          end
        end
        rsq_pkg::RSQ_ON_WAIT: begin
          if (fault_f || !trig[i]) begin
            state_next[i] = rsq_pkg::RSQ_OFF;
          end else if (tick_reg) begin
            cnt_next[i] = cnt_reg[i] - 4'h1;
            if (cnt_reg[i] <= 4'h1) begin
              state_next[i] = rsq_pkg::RSQ_ON;
            end
          end
        end
        rsq_pkg::RSQ_ON: begin
          if (fault_f) begin
            state_next[i] = rsq_pkg::RSQ_OFF;
          end else if (!trig[i]) begin
            state_next[i] = (off_dly[i] == 4'h0) ? rsq_pkg::RSQ_OFF : rsq_pkg::RSQ_OFF_WAIT;
            cnt_next[i] = off_dly[i];
          end
        end
        rsq_pkg::RSQ_OFF_WAIT: begin
          if (fault_f) begin
            state_next[i] = rsq_pkg::RSQ_OFF;
          end else if (trig[i]) begin
            state_next[i] = rsq_pkg::RSQ_ON;
          end else if (tick_reg) begin
            cnt_next[i] = cnt_reg[i] - 4'h1;
            if (cnt_reg[i] <= 4'h1) begin
              state_next[i] = rsq_pkg::RSQ_OFF;
            end
          end
        end
        default: begin
          state_next[i] = rsq_pkg::RSQ_OFF;
        end
      endcase
      en_next[i] = (state_next[i] == rsq_pkg::RSQ_ON) || (state_next[i] == rsq_pkg::RSQ_OFF_WAIT);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < RC; i++) begin
        state_reg[i] <= rsq_pkg::RSQ_OFF;
        cnt_reg[i] <= 4'h0;
      end
      en_reg <= '0;
    end else begin
      for (int i = 0; i < RC; i++) begin
        state_reg[i] <= state_next[i];
        cnt_reg[i] <= cnt_next[i];
      end
      en_reg <= en_next;
    end
  end

  assign rail_enable_o = en_reg;

  // ==========================================================================
  // setpoint selection; independent of sequencing state
  // ==========================================================================
  rsq_pkg::rsq_step_set_type step_set [rsq_pkg::STEP_COUNT];
  logic [2:0] req_bits;
  logic [1:0] src_sel [rsq_pkg::STEP_COUNT];
  logic [1:0] sleep_alt, scale_act, use_alt;
  logic [5:0] set_reg [rsq_pkg::STEP_COUNT];
  logic [5:0] set_next [rsq_pkg::STEP_COUNT];
  logic [5:0] lin_reg;
  logic ok_out_reg;
  logic [15:0] mv [rsq_pkg::STEP_COUNT];

  always_comb begin
    // alternate code sits in the upper byte; bits 7:6 are reserved and dropped
    step_set[0] = {cfg_reg[2][13:8], cfg_reg[2][5:0]};
    step_set[1] = {cfg_reg[3][13:8], cfg_reg[3][5:0]};
    req_bits = cfg_reg[rsq_pkg::SCALE_IDX][2:0];
    src_sel[0] = cfg_reg[rsq_pkg::SCALE_IDX][5:4];
    src_sel[1] = cfg_reg[rsq_pkg::SCALE_IDX][7:6];
    sleep_alt = cfg_reg[rsq_pkg::SCALE_IDX][9:8];
    for (int b = 0; b < rsq_pkg::STEP_COUNT; b++) begin
      // code 0 leaves the rail unscaled, 1 to 3 pick request a to c
      if (rsq_pkg::SCALE_FROM_PIN) begin
        scale_act[b] = scale_pin_f;
      end else begin
        scale_act[b] = (src_sel[b] != 2'h0) && req_bits[src_sel[b] - 2'h1];
      end
      use_alt[b] = scale_act[b] | (sleep_alt[b] & sleep_any);
      set_next[b] = use_alt[b] ? step_set[b].alternate : step_set[b].primary;
      mv[b] = rsq_pkg::BASE_MV + 16'(set_reg[b]) * rsq_pkg::STEP_MV;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      set_reg[0] <= 6'h00;
      set_reg[1] <= 6'h00;
      lin_reg <= 6'h00;
      ok_out_reg <= 1'b0;
    end else begin
      set_reg[0] <= set_next[0];
      set_reg[1] <= set_next[1];
      lin_reg <= cfg_reg[4][5:0];
      ok_out_reg <= rail_ok_f[rsq_pkg::GPIO_OK_RAIL];
    end
  end

  assign step_one_setpoint_o = set_reg[0];
  assign step_two_setpoint_o = set_reg[1];
  assign linear_reg_setpoint_o = lin_reg;
  assign gpio_power_ok_o = ok_out_reg;
  // push-pull output, always driven
  assign gpio_power_ok_oe_o = 1'b1;

  assign status_word = {14'h0000, scale_act, 1'b0, rail_ok_f, state_reg[2], state_reg[1],
                        state_reg[0]};
  assign target_word = {mv[1], mv[0]};

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence off_wait_done_s(int k);
    state_reg[k] == rsq_pkg::RSQ_OFF_WAIT && !fault_f && !trig[k] && tick_reg && cnt_reg[k] == 4'h1;
  endsequence

  genvar g;
  generate
    for (g = 0; g < RC; g++) begin : g_chk
      fault_cuts_a: assert property (fault_f |=> !en_reg[g])
        else $error("rail stayed enabled during fault");
      cancel_wait_a: assert property (
        state_reg[g] == rsq_pkg::RSQ_ON_WAIT && !trig[g] |=> state_reg[g] == rsq_pkg::RSQ_OFF
          && !en_reg[g])
        else $error("pending turn-on not cancelled");
      enable_cause_a: assert property ($rose(en_reg[g]) |-> $past(trig[g]))
        else $error("rail enabled without active trigger");
      zero_on_a: assert property (
        state_reg[g] == rsq_pkg::RSQ_OFF && trig[g] && !fault_f && on_dly[g] == 4'h0
          |=> en_reg[g])
        else $error("zero turn-on delay not immediate");
      off_delay_a: assert property (
        state_reg[g] == rsq_pkg::RSQ_ON && !trig[g] && !fault_f && off_dly[g] != 4'h0
          |=> en_reg[g] && state_reg[g] == rsq_pkg::RSQ_OFF_WAIT)
        else $error("turn-off delay skipped");
      off_done_a: assert property (off_wait_done_s(g) |=> !en_reg[g] ##1 !en_reg[g] || trig[g])
        else $error("rail not off after turn-off delay");
      on_wait_hold_a: assert property (
        state_reg[g] == rsq_pkg::RSQ_ON_WAIT && trig[g] && !fault_f && !tick_reg
          |=> state_reg[g] == rsq_pkg::RSQ_ON_WAIT && !en_reg[g])
        else $error("rail enabled before turn-on delay ran out");
    end
  endgenerate

  // the reset edge itself loads zero setpoints, so these checks start one edge later
  setpoint_pick_a: assert property (
    !rst_i && use_alt[1] |=> step_two_setpoint_o == $past(step_set[1].alternate))
    else $error("alternate setpoint not applied");
  primary_pick_a: assert property (
    !rst_i && !use_alt[0] |=> step_one_setpoint_o == $past(step_set[0].primary))
    else $error("primary setpoint not applied");
  rail_one_free_a: assert property (
    !rst_i && src_sel[0] == 2'h0 && !rsq_pkg::SCALE_FROM_PIN && !(sleep_alt[0] && sleep_any)
      |=> step_one_setpoint_o == $past(step_set[0].primary))
    else $error("unbound rail scaled");
  sleep_alt_a: assert property (
    !rst_i && sleep_alt[0] && sleep_any
      |=> step_one_setpoint_o == $past(step_set[0].alternate))
    else $error("sleep setpoint not applied");
  ok_mirror_a: assert property (
    ##1 gpio_power_ok_o == $past(rail_ok_f[rsq_pkg::GPIO_OK_RAIL]))
    else $error("power ok pin does not follow rail");
  ack_pulse_a: assert property (ack_reg |=> !ack_reg)
    else $error("bus ack longer than one cycle");
  // the answer is registered: exactly one edge after the request is taken
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !ack_reg |=> ack_reg)
    else $error("bus request not answered next cycle");
  tick_gap_a: assert property (tick_reg |=> !tick_reg)
    else $error("delay tick longer than one cycle");
endmodule

// File: verilog/rsq_pkg.sv
package rsq_pkg;
  // ==========================================================================
  // sizes and timing
  // ==========================================================================
  localparam int RAIL_COUNT = 3;
  localparam int STEP_COUNT = 2;
  localparam int SYNC_W = 11;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DELAY_TICK_NS = 1000;
  // least time, so round up to whole cycles
  localparam int TICK_CYCLES = (DELAY_TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

  // ==========================================================================
  // sequencer states
  // ==========================================================================
  typedef enum logic [3:0] {
    RSQ_OFF = 4'b0001,
    RSQ_ON_WAIT = 4'b0010,
    RSQ_ON = 4'b0100,
    RSQ_OFF_WAIT = 4'b1000
  } rsq_state_type;

  // ==========================================================================
  // factory image: trigger source per output, scaling from pin or bits
  // ==========================================================================
  localparam logic [2:0] TRIG_INPUT_OK = 3'h0;
  localparam logic [2:0] TRIG_EXT_GOOD = 3'h1;
  localparam logic [2:0] TRIG_GPIO = 3'h2;
  localparam logic [2:0] TRIG_RAIL_OK0 = 3'h3;
  localparam logic [2:0] TRIG_RAIL_OK1 = 3'h4;
  localparam logic [2:0] TRIG_RAIL_OK2 = 3'h5;
  localparam logic [2:0] TRIG_SEL [RAIL_COUNT] = '{TRIG_INPUT_OK, TRIG_RAIL_OK0, TRIG_RAIL_OK1};
  localparam logic SCALE_FROM_PIN = 1'b0;
  localparam int GPIO_OK_RAIL = 2;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam int CFG_COUNT = 6;
  localparam logic [7:0] ON_DLY_OFS = 8'h00;
  localparam logic [7:0] OFF_DLY_OFS = 8'h04;
  localparam logic [7:0] STEP_ONE_OFS = 8'h08;
  localparam logic [7:0] STEP_TWO_OFS = 8'h0c;
  localparam logic [7:0] LIN_SET_OFS = 8'h10;
  localparam logic [7:0] SCALE_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] TARGET_OFS = 8'h1c;
  localparam int SCALE_IDX = 5;
  localparam logic [31:0] CFG_MASK [CFG_COUNT] = '{32'h0000_0fff, 32'h0000_0fff,
    32'h0000_3f3f, 32'h0000_3f3f, 32'h0000_003f, 32'h0000_03f7};
  localparam logic [31:0] CFG_RESET [CFG_COUNT] = '{32'h0000_0210, 32'h0000_0012,
    32'h0000_0406, 32'h0000_0a10, 32'h0000_0018, 32'h0000_0040};

  // ==========================================================================
  // setpoint code to millivolts
  // ==========================================================================
  localparam logic [15:0] BASE_MV = 16'h0258;
  localparam logic [15:0] STEP_MV = 16'h0032;

  typedef struct packed {
    logic [5:0] alternate;
    logic [5:0] primary;
  } rsq_step_set_type;
endpackage

// File: dv/rsq_rail_model.sv
`timescale 1ns/1ps
// ============================================================================
// regulator outputs: power ok trails the enable by a ramp time
// ============================================================================
module rsq_rail_model #(
  parameter int RISE_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic [2:0] rail_enable_i,
  output logic [2:0] power_ok_signal_o
);
  int cnt [3];

  initial power_ok_signal_o = 3'h0;

  // a rail reports ok only after its ramp, so a chained output must really wait
  always @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (rail_enable_i[i] !== 1'b1) begin
        cnt[i] <= 0;
        power_ok_signal_o[i] <= 1'b0;
      end else if (cnt[i] < RISE_CYCLES) begin
        cnt[i] <= cnt[i] + 1;
      end else begin
        power_ok_signal_o[i] <= 1'b1;
      end
    end
  end
endmodule

// File: dv/test_rsq_sequencer.sv
`timescale 1ns/1ps
`define CHECK_EQ(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module test_rsq_sequencer;
  // ==========================================================================
  // stimulus and wiring
  // ==========================================================================
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack;
  logic input_ok = 1'b0;
  logic tied_lo = 1'b0;
  logic scale_pin = 1'b0;
  logic light_sleep = 1'b0;
  logic deep_sleep = 1'b0;
  logic shutdown = 1'b0;
  logic fault = 1'b0;
  logic [2:0] rail_ok;
  logic [2:0] rail_en;
  logic [5:0] step_one;
  logic [5:0] step_two;
  logic [5:0] lin_set;
  logic gpio_ok;
  logic gpio_ok_oe;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  rsq_sequencer DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .input_supply_ok_i(input_ok),
    .external_power_good_i(tied_lo), .gpio_trigger_i(tied_lo), .gpio_scaling_i(scale_pin),
    .power_ok_signal_i(rail_ok), .light_sleep_i(light_sleep), .deep_sleep_state_i(deep_sleep),
    .shutdown_i(shutdown), .fault_i(fault), .rail_enable_o(rail_en),
    .step_one_setpoint_o(step_one), .step_two_setpoint_o(step_two),
    .linear_reg_setpoint_o(lin_set), .gpio_power_ok_o(gpio_ok),
    .gpio_power_ok_oe_o(gpio_ok_oe));

  rsq_rail_model #(.RISE_CYCLES(8)) rails (.clk_i(clk), .rail_enable_i(rail_en),
    .power_ok_signal_o(rail_ok));

  // ==========================================================================
  // bus and wait tasks, entered just after a rising edge
  // ==========================================================================
  task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (wb_ack !== 1'b1) fails++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wb_access(1'b1, adr, dat, rd);
    @(posedge clk);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb_access(1'b0, adr, 32'h0000_0000, rd);
    `CHECK_EQ(what, exp, rd)
  endtask

  // bounded wait; the task compares afterwards, so a timeout shows as a mismatch
  task automatic wait_rail(input int idx, input logic val, input int max);
    int n;
    n = 0;
    while (rail_en[idx] !== val && n < max) begin
      @(posedge clk);
      n++;
    end
    `CHECK_EQ("rail enable", val, rail_en[idx])
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    logic [31:0] dflt [6];
    dflt = '{32'h0000_0210, 32'h0000_0012, 32'h0000_0406, 32'h0000_0a10, 32'h0000_0018,
      32'h0000_0040};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 6; i++) rd_chk("default", 8'(i * 4), dflt[i]);
    rd_chk("unmapped", 8'h40, 32'h0000_0000);
    wr(8'h1c, 32'hffff_ffff);
    rd_chk("target mv", 8'h1c, 32'h0578_0384);
    $display("test registers done");

    `CHECK_EQ("step one", 6'h06, step_one)
    `CHECK_EQ("step two", 6'h10, step_two)
    wr(8'h14, 32'h0000_0041);
    `CHECK_EQ("step two", 6'h0a, step_two)
    `CHECK_EQ("step one", 6'h06, step_one)
    rd_chk("target mv", 8'h1c, 32'h044c_0384);
    for (int s = 1; s < 4; s++) begin
      wr(8'h14, 32'((s << 4) | (1 << (s - 1))));
      `CHECK_EQ("step one", 6'h04, step_one)
      wr(8'h14, 32'((s << 4) | (1 << (s % 3))));
      `CHECK_EQ("step one", 6'h06, step_one)
    end
    wr(8'h10, 32'h0000_001c); // host moves the setpoint in small steps
    wr(8'h10, 32'h0000_0020);
    `CHECK_EQ("linear", 6'h20, lin_set)
    scale_pin <= 1'b1;
    repeat (8) @(posedge clk);
    `CHECK_EQ("pin ignored", 6'h10, step_two)
    scale_pin <= 1'b0;
    wr(8'h14, 32'h0000_0040);
    $display("test setpoints done");

    // on delay of two ticks on output zero: between one and two microseconds
    wr(8'h00, 32'h0000_0002);
    wr(8'h04, 32'h0000_0002);
    input_ok <= 1'b1;
    repeat (150) @(posedge clk);
    `CHECK_EQ("early enable", 1'b0, rail_en[0])
    wait_rail(0, 1'b1, 300);
    `CHECK_EQ("chained early", 1'b0, rail_en[1])
    wait_rail(1, 1'b1, 40);
    wait_rail(2, 1'b1, 40);
    repeat (20) @(posedge clk);
    `CHECK_EQ("gpio power ok", 2'b11, {gpio_ok, gpio_ok_oe})
    wr(8'h14, 32'h0000_0041);
    `CHECK_EQ("enables", 3'h7, rail_en)
    `CHECK_EQ("step two", 6'h0a, step_two)
    wr(8'h14, 32'h0000_0040);
    $display("test power up done");

    // rail one takes its alternate setpoint in either sleep, not on shutdown
    wr(8'h14, 32'h0000_0140);
    for (int k = 0; k < 3; k++) begin
      light_sleep <= (k == 0);
      deep_sleep <= (k == 1);
      shutdown <= (k == 2);
      repeat (100) @(posedge clk);
      `CHECK_EQ("held by off delay", 1'b1, rail_en[0])
      `CHECK_EQ("no off delay", 1'b0, rail_en[1])
      `CHECK_EQ("sleep setpoint", (k < 2) ? 6'h04 : 6'h06, step_one)
      wait_rail(0, 1'b0, 400);
      light_sleep <= 1'b0;
      deep_sleep <= 1'b0;
      shutdown <= 1'b0;
      wait_rail(0, 1'b1, 450);
      wait_rail(2, 1'b1, 100);
    end
    wr(8'h14, 32'h0000_0040);
    $display("test power down done");

    fault <= 1'b1;
    wait_rail(0, 1'b0, 8);
    `CHECK_EQ("fault off", 3'h0, rail_en)
    input_ok <= 1'b0;
    repeat (10) @(posedge clk);
    fault <= 1'b0;
    repeat (10) @(posedge clk);
    input_ok <= 1'b1;
    repeat (100) @(posedge clk);
    input_ok <= 1'b0;
    repeat (400) @(posedge clk);
    `CHECK_EQ("cancelled", 1'b0, rail_en[0])
    input_ok <= 1'b1;
    repeat (150) @(posedge clk);
    `CHECK_EQ("restarted", 1'b0, rail_en[0])
    wait_rail(0, 1'b1, 300);
    $display("test fault and cancel done");

    // a reset in mid-run must bring the delay fields back to their defaults
    wr(8'h00, 32'h0000_0333);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHECK_EQ("reset enables", 3'h0, rail_en)
    rd_chk("reset default", 8'h00, 32'h0000_0210);
    $display("test reset done");
    summarize();
  end
endmodule
